// ---- src/ifeb_params.svh ----
// Constants of the interrupt flag and enable bank: offsets, bit positions, reset values.
`ifndef IFEB_PARAMS_SVH
`define IFEB_PARAMS_SVH

// Byte offsets of the register words.
`define IFEB_OFF_CTL2 8'h00
`define IFEB_OFF_MULTI_FUNCTION_IRQ_ZERO 8'h04
`define IFEB_OFF_CTL1 8'h08
`define IFEB_OFF_STAT 8'h0C
`define IFEB_OFF_MASK 8'h10

// Bit positions inside control two.
`define IFEB_C2_SER_F 6
`define IFEB_C2_EXT_F 5
`define IFEB_C2_TB_F 4
`define IFEB_C2_SER_E 2
`define IFEB_C2_EXT_E 1
`define IFEB_C2_TB_E 0

// Bit positions inside the multi-function register.
`define IFEB_MF_A_F 5
`define IFEB_MF_P_F 4
`define IFEB_MF_A_E 1
`define IFEB_MF_P_E 0

// Global enable position in control one.
`define IFEB_C1_GLOB 0

// Reset values.
`define IFEB_RST_BYTE 8'h00
`define IFEB_RST_SRC 5'h00

// Bus response codes.
`define IFEB_RESP_OKAY 2'h0
`define IFEB_RESP_SLVERR 2'h2

`endif

// ---- src/ifeb_pkg.sv ----
// Types shared by the interrupt flag and enable bank.
package ifeb_pkg;

   // One bit per interrupt source, same order everywhere.
   typedef struct packed {
      logic serial;
      logic ext;
      logic tb;
      logic cta;
      logic ctp;
   } ifeb_src_s;

   // Read channel states of the bus slave.
   typedef enum logic [1:0] {
      IFEB_RS_IDLE = 2'b01,
      IFEB_RS_RESP = 2'b10
   } ifeb_rstate_e;

endpackage : ifeb_pkg

// ---- src/ifeb_axil_slave.sv ----
// AXI4-Lite slave front end of the interrupt flag and enable bank.
`timescale 1ns/1ps
`include "ifeb_params.svh"
module ifeb_axil_slave (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset_n,
   // Write address and data channels.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // Write response channel.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read channels.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Register file side.
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data,
   input wire logic wr_ok,
   output logic rd_en,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);

   logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
   logic [7:0] aw_addr_r, aw_addr_nxt, w_data_r, w_data_nxt;
   logic awready_r, awready_nxt, wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   ifeb_pkg::ifeb_rstate_e rs_r, rs_nxt;

   // Address and data are caught on their own; the write fires once both are held.
   always_comb
   begin
      aw_held_nxt = aw_held_r;
      aw_addr_nxt = aw_addr_r;
      w_held_nxt = w_held_r;
      w_data_nxt = w_data_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      wr_en = aw_held_r && w_held_r && !bvalid_r;
      if (s_axi_awvalid && awready_r)
      begin
         aw_held_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r)
      begin
         w_held_nxt = 1'b1;
         // Only the low lane holds register bits; a write without it writes zero to the register.
         w_data_nxt = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end
      if (bvalid_r && s_axi_bready)
         bvalid_nxt = 1'b0;
      if (wr_en)
      begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = wr_ok ? `IFEB_RESP_OKAY : `IFEB_RESP_SLVERR;
      end
      awready_nxt = !aw_held_nxt && !bvalid_nxt;
      wready_nxt = !w_held_nxt && !bvalid_nxt;
   end

   // Read: one cycle from the taken address to valid data.
   always_comb
   begin
      rs_nxt = rs_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      rd_en = 1'b0;
      case (rs_r)
         ifeb_pkg::IFEB_RS_IDLE:
         begin
            // The address counts as taken only while ready is shown, never in the reset gap.
            if (s_axi_arvalid && arready_r)
            begin
               rd_en = 1'b1;
               rdata_nxt = rd_data;
               rresp_nxt = rd_ok ? `IFEB_RESP_OKAY : `IFEB_RESP_SLVERR;
               rs_nxt = ifeb_pkg::IFEB_RS_RESP;
            end
         end
         ifeb_pkg::IFEB_RS_RESP:
         begin
            if (s_axi_rready)
               rs_nxt = ifeb_pkg::IFEB_RS_IDLE;
         end
         default: rs_nxt = ifeb_pkg::IFEB_RS_IDLE;
      endcase
      arready_nxt = (rs_nxt == ifeb_pkg::IFEB_RS_IDLE);
      rvalid_nxt = (rs_nxt == ifeb_pkg::IFEB_RS_RESP);
   end

   // Channel state registers.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_held_r <= 1'b0;
         w_data_r <= 8'h00;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'h0;
         rs_r <= ifeb_pkg::IFEB_RS_IDLE;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= 2'h0;
      end
      else
      begin
         aw_held_r <= aw_held_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_held_r <= w_held_nxt;
         w_data_r <= w_data_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rs_r <= rs_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign wr_addr = aw_addr_r;
   assign wr_data = w_data_r;
   assign rd_addr = s_axi_araddr;

endmodule : ifeb_axil_slave

// ---- src/ifeb_top.sv ----
// Interrupt flag and enable bank with its register file and service request outputs.
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ifeb_params.svh"
module ifeb_top #(
   // Set to 1 for the larger variant that carries the serial transfer source.
   parameter bit LARGE_VARIANT = 1'b1
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset_n,
   // Write address and data channels.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // Write response channel.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read channels.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Source events, one-cycle pulses from logic on this clock.
   input wire ifeb_pkg::ifeb_src_s src_event,
   // Service acknowledges that clear the matching flags.
   input wire ifeb_pkg::ifeb_src_s svc_ack,
   // Requests offered to the servicing logic.
   output ifeb_pkg::ifeb_src_s svc_req,
   // Summary interrupt of unmasked sticky status.
   output logic irq
);

   ifeb_pkg::ifeb_src_s flag_r, flag_nxt, en_r, en_nxt, stat_r, stat_nxt, mask_r, mask_nxt;
   ifeb_pkg::ifeb_src_s req_r, req_nxt, impl;
   logic glob_r, glob_nxt;
   logic irq_r, irq_nxt;
   logic wr_en, rd_en;
   logic [7:0] wr_addr, wr_data, rd_addr;
   logic [31:0] rd_data;

   // True for the five word offsets that hold registers.
   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a == `IFEB_OFF_CTL2) || (a == `IFEB_OFF_MULTI_FUNCTION_IRQ_ZERO) || (a == `IFEB_OFF_CTL1) ||
                    (a == `IFEB_OFF_STAT) || (a == `IFEB_OFF_MASK);
   endfunction : addr_mapped

   // Packs the control two byte; bits 7 and 3 stay zero, 6 and 2 only on the large part.
   function automatic logic [7:0] pack_ctl2(input ifeb_pkg::ifeb_src_s f,
                                            input ifeb_pkg::ifeb_src_s e);
      logic [7:0] v;
      v = 8'h00;
      v[`IFEB_C2_SER_F] = f.serial;
      v[`IFEB_C2_EXT_F] = f.ext;
      v[`IFEB_C2_TB_F] = f.tb;
      v[`IFEB_C2_SER_E] = e.serial;
      v[`IFEB_C2_EXT_E] = e.ext;
      v[`IFEB_C2_TB_E] = e.tb;
      pack_ctl2 = v;
   endfunction : pack_ctl2

   // Packs the multi-function byte; bits 7:6 and 3:2 stay zero.
   function automatic logic [7:0] pack_multi_function_irq_zero(input ifeb_pkg::ifeb_src_s f,
                                            input ifeb_pkg::ifeb_src_s e);
      logic [7:0] v;
      v = 8'h00;
      v[`IFEB_MF_A_F] = f.cta;
      v[`IFEB_MF_P_F] = f.ctp;
      v[`IFEB_MF_A_E] = e.cta;
      v[`IFEB_MF_P_E] = e.ctp;
      pack_multi_function_irq_zero = v;
   endfunction : pack_multi_function_irq_zero

   // Packs a status or mask word in source order, serial at the top.
   function automatic logic [7:0] pack_src(input ifeb_pkg::ifeb_src_s s);
      pack_src = {3'h0, s};
   endfunction : pack_src

   // Bus front end; it answers unmapped offsets with SLVERR.
   ifeb_axil_slave u_bus (
      .clk(clk),
      .reset_n(reset_n),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_ok(addr_mapped(wr_addr)),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(addr_mapped(rd_addr))
   );

   // The serial source simply does not exist on the small variant.
   assign impl = '{serial: LARGE_VARIANT, ext: 1'b1, tb: 1'b1, cta: 1'b1, ctp: 1'b1};

   // Read mux; unmapped offsets and all bits above the low byte read as zero.
   always_comb
   begin
      rd_data = 32'h00000000;
      case (rd_addr)
         `IFEB_OFF_CTL2: rd_data[7:0] = pack_ctl2(flag_r, en_r);
         `IFEB_OFF_MULTI_FUNCTION_IRQ_ZERO: rd_data[7:0] = pack_multi_function_irq_zero(flag_r, en_r);
         `IFEB_OFF_CTL1: rd_data[`IFEB_C1_GLOB] = glob_r;
         `IFEB_OFF_STAT: rd_data[7:0] = pack_src(stat_r);
         `IFEB_OFF_MASK: rd_data[7:0] = pack_src(mask_r);
         default: rd_data = 32'h00000000;
      endcase
   end

   // Flags and enables: an event wins over both a software write and an acknowledge,
   // so a request arriving in the clearing cycle is never lost.
   always_comb
   begin
      flag_nxt = flag_r & ~svc_ack;
      en_nxt = en_r;
      glob_nxt = glob_r;
      mask_nxt = mask_r;
      if (wr_en && wr_addr == `IFEB_OFF_CTL2)
      begin
         flag_nxt.serial = wr_data[`IFEB_C2_SER_F];
         flag_nxt.ext = wr_data[`IFEB_C2_EXT_F];
         flag_nxt.tb = wr_data[`IFEB_C2_TB_F];
         en_nxt.serial = wr_data[`IFEB_C2_SER_E];
         en_nxt.ext = wr_data[`IFEB_C2_EXT_E];
         en_nxt.tb = wr_data[`IFEB_C2_TB_E];
      end
      if (wr_en && wr_addr == `IFEB_OFF_MULTI_FUNCTION_IRQ_ZERO)
      begin
         flag_nxt.cta = wr_data[`IFEB_MF_A_F];
         flag_nxt.ctp = wr_data[`IFEB_MF_P_F];
         en_nxt.cta = wr_data[`IFEB_MF_A_E];
         en_nxt.ctp = wr_data[`IFEB_MF_P_E];
      end
      if (wr_en && wr_addr == `IFEB_OFF_CTL1)
         glob_nxt = wr_data[`IFEB_C1_GLOB];
      if (wr_en && wr_addr == `IFEB_OFF_MASK)
         mask_nxt = wr_data[4:0];
      flag_nxt = (flag_nxt | src_event) & impl;
      en_nxt = en_nxt & impl;
      mask_nxt = mask_nxt & impl;
   end

   // Sticky status is write-one-to-clear, and a new event beats the clear.
   always_comb
   begin
      stat_nxt = stat_r;
      if (wr_en && wr_addr == `IFEB_OFF_STAT)
         stat_nxt = stat_r & ~wr_data[4:0];
      stat_nxt = (stat_nxt | src_event) & impl;
   end

   // Requests need flag, enable and the global enable together.
   always_comb
   begin
      req_nxt = glob_r ? (flag_r & en_r) : `IFEB_RST_SRC;
      irq_nxt = |(stat_r & mask_r);
   end

   // State registers; every flag and enable is clear after reset.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         flag_r <= `IFEB_RST_SRC;
         en_r <= `IFEB_RST_SRC;
         glob_r <= 1'b0;
         stat_r <= `IFEB_RST_SRC;
         mask_r <= `IFEB_RST_SRC;
         req_r <= `IFEB_RST_SRC;
         irq_r <= 1'b0;
      end
      else
      begin
         flag_r <= flag_nxt;
         en_r <= en_nxt;
         glob_r <= glob_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         req_r <= req_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign svc_req = req_r;
   assign irq = irq_r;

   // Checks of the flag, enable and request relations.
   property p_ext_set;
      @(posedge clk) disable iff (!reset_n) src_event.ext |=> flag_r.ext;
   endproperty
   a_ext_set: assert property (p_ext_set) else $error("pin one event did not set flag");

   property p_tb_set;
      @(posedge clk) disable iff (!reset_n) src_event.tb |=> flag_r.tb;
   endproperty
   a_tb_set: assert property (p_tb_set) else $error("time base event did not set flag");

   property p_ext_req;
      @(posedge clk) disable iff (!reset_n)
         (flag_r.ext && en_r.ext && glob_r) |=> svc_req.ext;
   endproperty
   a_ext_req: assert property (p_ext_req) else $error("pin one request missing");

   property p_tb_gate;
      @(posedge clk) disable iff (!reset_n) !en_r.tb |=> !svc_req.tb;
   endproperty
   a_tb_gate: assert property (p_tb_gate) else $error("time base request while disabled");

   property p_serial_absent;
      @(posedge clk) disable iff (!reset_n) !LARGE_VARIANT |-> !flag_r.serial && !en_r.serial;
   endproperty
   a_serial_absent: assert property (p_serial_absent) else $error("serial bits on small part");

   property p_cta_set;
      @(posedge clk) disable iff (!reset_n) src_event.cta |=> flag_r.cta && stat_r.cta;
   endproperty
   a_cta_set: assert property (p_cta_set) else $error("timer A event did not set flag");

   property p_ctp_sticky;
      @(posedge clk) disable iff (!reset_n)
         (flag_r.ctp && !svc_ack.ctp && !wr_en) |=> flag_r.ctp;
   endproperty
   a_ctp_sticky: assert property (p_ctp_sticky) else $error("timer P flag dropped alone");

   property p_cta_req;
      @(posedge clk) disable iff (!reset_n)
         svc_req.cta |-> $past(flag_r.cta) && $past(en_r.cta);
   endproperty
   a_cta_req: assert property (p_cta_req) else $error("timer A request without cause");

   property p_rsvd_zero;
      @(posedge clk) disable iff (!reset_n)
         (rd_addr == `IFEB_OFF_CTL2 || rd_addr == `IFEB_OFF_MULTI_FUNCTION_IRQ_ZERO) |->
            (rd_data & ((rd_addr == `IFEB_OFF_CTL2) ? 32'hFFFF_FF88 : 32'hFFFF_FFCC)) == 32'h0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit reads one");

   property p_ctp_req;
      @(posedge clk) disable iff (!reset_n)
         (flag_r.ctp && en_r.ctp && glob_r) ##1 1'b1 |-> svc_req.ctp;
   endproperty
   a_ctp_req: assert property (p_ctp_req) else $error("timer P request missing");

   property p_req_cause;
      @(posedge clk) disable iff (!reset_n)
         $rose(svc_req.ext) |-> $past(flag_r.ext & en_r.ext);
   endproperty
   a_req_cause: assert property (p_req_cause) else $error("request rose without flag");

   property p_glob_off;
      @(posedge clk) disable iff (!reset_n) !glob_r |=> svc_req == `IFEB_RST_SRC;
   endproperty
   a_glob_off: assert property (p_glob_off) else $error("request with global off");

   // Main scenarios worth seeing.
   c_ext_req: cover property (@(posedge clk) disable iff (!reset_n) $rose(svc_req.ext));
   c_irq: cover property (@(posedge clk) disable iff (!reset_n) $rose(irq));
   c_ack_race: cover property (@(posedge clk) disable iff (!reset_n)
      svc_ack.tb && src_event.tb);
   c_serial_req: cover property (@(posedge clk) disable iff (!reset_n) svc_req.serial);

endmodule : ifeb_top

// ---- src/ifeb_unused_placeholder_removed.sv ----
// Intentionally empty compilation unit kept out of the build.

// ---- testbench/irq_flag_enable_bank_bench.sv ----
// Self-checking bench for the interrupt flag and enable bank, driven over its register bus.
`timescale 1ns/1ps
`include "ifeb_params.svh"
module irq_flag_enable_bank_bench;

   // Bus, event and request signals of the bank.
   logic clk;
   logic reset_n;
   logic [7:0] s_axi_awaddr;
   logic s_axi_awvalid;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_wvalid;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready;
   logic [7:0] s_axi_araddr;
   logic s_axi_arvalid;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready;
   ifeb_pkg::ifeb_src_s src_event;
   ifeb_pkg::ifeb_src_s svc_ack;
   ifeb_pkg::ifeb_src_s svc_req;
   logic irq;
   int err_count;
   int comparisons;
   logic [7:0] reg_off;
   logic [31:0] f_bit;
   logic [31:0] e_bit;
   logic [31:0] s_bit;

   // Larger variant, so the serial transfer source is present.
   ifeb_top #(.LARGE_VARIANT(1'b1)) DUT (
      .clk(clk), .reset_n(reset_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .src_event(src_event), .svc_ack(svc_ack), .svc_req(svc_req), .irq(irq)
   );

   // Free-running 50 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish

   // Compares one observed value against its expectation.
   task automatic check(input logic [31:0] seen, input logic [31:0] expected);
      comparisons++;
      if (seen !== expected)
      begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
      end
   endtask : check

   // A wait that runs out counts as a mismatch and closes the run.
   task automatic give_up();
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, 32'h0, 32'h1);
      tally_and_finish();
   endtask : give_up

   // One write; an edge passes first so bready is never driven twice in one step.
   task automatic axi_write(input logic [7:0] addr, input logic [31:0] data,
                            output logic [1:0] resp);
      int n;
      logic aw_done;
      logic w_done;
      @(posedge clk);
      aw_done = 1'b0;
      w_done = 1'b0;
      n = 0;
      s_axi_awaddr <= addr;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= data;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge clk);
         n++;
         if (!aw_done && s_axi_awready === 1'b1)
         begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready === 1'b1)
         begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
         if (n > 50)
            give_up();
      end
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
         if (n > 50)
            give_up();
      end
      while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_write

   // One read; rready stays high until rvalid is sampled.
   task automatic axi_read(input logic [7:0] addr, output logic [31:0] data,
                           output logic [1:0] resp);
      int n;
      @(posedge clk);
      n = 0;
      s_axi_araddr <= addr;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (n > 50)
            give_up();
      end
      while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
         if (n > 50)
            give_up();
      end
      while (s_axi_rvalid !== 1'b1);
      data = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_read

   // Write that must be accepted with the given response code.
   task automatic wr(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] exp_resp);
      logic [1:0] resp;
      axi_write(addr, data, resp);
      check({30'h0, resp}, {30'h0, exp_resp});
   endtask : wr

   // Read whose data and response code are both compared.
   task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input logic [1:0] exp_resp);
      logic [31:0] data;
      logic [1:0] resp;
      axi_read(addr, data, resp);
      check(data, exp);
      check({30'h0, resp}, {30'h0, exp_resp});
   endtask : rd

   // One-cycle pulse on the events or the acknowledges, then time to settle.
   task automatic pulse(input logic is_ack, input logic [4:0] m);
      @(posedge clk);
      if (is_ack)
         svc_ack <= m;
      else
         src_event <= m;
      @(posedge clk);
      src_event <= 5'h00;
      svc_ack <= 5'h00;
      repeat (3) @(posedge clk);
   endtask : pulse

   // Main sequence: reset, register map, then every source through its whole life.
   initial
   begin
      err_count = 0;
      comparisons = 0;
      reset_n = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      src_event = 5'h00;
      svc_ack = 5'h00;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      // Everything starts cleared.
      rd(`IFEB_OFF_CTL2, 32'h0, `IFEB_RESP_OKAY);
      rd(`IFEB_OFF_MULTI_FUNCTION_IRQ_ZERO, 32'h0, `IFEB_RESP_OKAY);
      rd(`IFEB_OFF_CTL1, 32'h0, `IFEB_RESP_OKAY);
      // All ones written: only implemented bits stick.
      wr(`IFEB_OFF_CTL2, 32'hFFFF_FFFF, `IFEB_RESP_OKAY);
      rd(`IFEB_OFF_CTL2, 32'h77, `IFEB_RESP_OKAY);
      wr(`IFEB_OFF_MULTI_FUNCTION_IRQ_ZERO, 32'hFFFF_FFFF, `IFEB_RESP_OKAY);
      rd(`IFEB_OFF_MULTI_FUNCTION_IRQ_ZERO, 32'h33, `IFEB_RESP_OKAY);
      wr(`IFEB_OFF_CTL2, 32'h0, `IFEB_RESP_OKAY);
      wr(`IFEB_OFF_MULTI_FUNCTION_IRQ_ZERO, 32'h0, `IFEB_RESP_OKAY);
      rd(`IFEB_OFF_CTL2, 32'h0, `IFEB_RESP_OKAY);
      rd(`IFEB_OFF_MULTI_FUNCTION_IRQ_ZERO, 32'h0, `IFEB_RESP_OKAY);
      // An unmapped word is refused and reads as zero.
      wr(8'h14, 32'hFF, `IFEB_RESP_SLVERR);
      rd(8'h14, 32'h0, `IFEB_RESP_SLVERR);
      // Each source in turn: serial, pin one, time base, timer A, timer P.
      for (int i = 4; i >= 0; i--)
      begin
         reg_off = (i >= 2) ? `IFEB_OFF_CTL2 : `IFEB_OFF_MULTI_FUNCTION_IRQ_ZERO;
         f_bit = (i >= 2) ? (32'h1 << (i + 2)) : (32'h1 << (i + 4));
         e_bit = (i >= 2) ? (32'h1 << (i - 2)) : (32'h1 << i);
         s_bit = 32'h1 << i;
         wr(`IFEB_OFF_CTL1, 32'h0, `IFEB_RESP_OKAY);
         wr(`IFEB_OFF_MASK, 32'h0, `IFEB_RESP_OKAY);
         wr(reg_off, e_bit, `IFEB_RESP_OKAY);
         pulse(1'b0, s_bit[4:0]);
         // Enabled but globally gated: nothing is offered, the interrupt is masked.
         check({27'h0, svc_req}, 32'h0);
         check({31'h0, irq}, 32'h0);
         rd(reg_off, f_bit | e_bit, `IFEB_RESP_OKAY);
         rd(`IFEB_OFF_STAT, s_bit, `IFEB_RESP_OKAY);
         wr(`IFEB_OFF_MASK, s_bit, `IFEB_RESP_OKAY);
         repeat (3) @(posedge clk);
         check({31'h0, irq}, 32'h1);
         wr(`IFEB_OFF_CTL1, 32'h1, `IFEB_RESP_OKAY);
         repeat (3) @(posedge clk);
         check({27'h0, svc_req}, s_bit);
         // The acknowledge clears the flag and withdraws the request.
         pulse(1'b1, s_bit[4:0]);
         check({27'h0, svc_req}, 32'h0);
         rd(reg_off, e_bit, `IFEB_RESP_OKAY);
         // Flag set by software with its enable off: still no request.
         wr(reg_off, f_bit, `IFEB_RESP_OKAY);
         repeat (3) @(posedge clk);
         check({27'h0, svc_req}, 32'h0);
         rd(reg_off, f_bit, `IFEB_RESP_OKAY);
         wr(reg_off, 32'h0, `IFEB_RESP_OKAY);
         // Status clears on a written one and takes the interrupt down.
         wr(`IFEB_OFF_STAT, s_bit, `IFEB_RESP_OKAY);
         rd(`IFEB_OFF_STAT, 32'h0, `IFEB_RESP_OKAY);
         repeat (3) @(posedge clk);
         check({31'h0, irq}, 32'h0);
      end
      // An event in the acknowledge cycle wins, so the time base flag and its status bit end up set.
      @(posedge clk);
      src_event <= 5'h04;
      svc_ack <= 5'h04;
      @(posedge clk);
      src_event <= 5'h00;
      svc_ack <= 5'h00;
      rd(`IFEB_OFF_CTL2, 32'h10, `IFEB_RESP_OKAY);
      rd(`IFEB_OFF_STAT, 32'h04, `IFEB_RESP_OKAY);
      tally_and_finish();
   end

endmodule : irq_flag_enable_bank_bench
